// *** lpsd_pkg.sv ***
// Purpose: constants for the command decoder and mode registers of the low-power SDRAM model
// Assumes: single core clock, pins sampled on its rising edge
// Notes: field positions follow the address-line layout of the mode-load opcode
package lpsd_pkg;
	localparam int LPSD_ADDR_W = 12;
	localparam int LPSD_DATA_W = 32;
	localparam int LPSD_LANES = 4;
	localparam int LPSD_ROW_W = 12;
	localparam int LPSD_COL_W = 9;
	localparam int LPSD_BANKS = 4;
	// Base mode register fields
	localparam int LPSD_BL_LSB = 0;
	localparam int LPSD_BT_BIT = 3;
	localparam int LPSD_CL_LSB = 4;
	localparam int LPSD_WB_BIT = 9;
	// Extended register fields
	localparam int LPSD_PARTIAL_REFRESH_FIELD_LSB = 0;
	localparam int LPSD_DRV_LSB = 5;
	localparam int LPSD_AP_BIT = 10;
	localparam int LPSD_MASK_RD_DLY = 2;
	localparam logic [13:0] LPSD_MODE_RST = 14'h0020;
	localparam logic [13:0] LPSD_EXT_RST = 14'h0000;
	localparam logic [2:0] LPSD_CL1 = 3'h1;
	localparam logic [2:0] LPSD_CL2 = 3'h2;
	localparam logic [2:0] LPSD_CL3 = 3'h3;
	localparam logic [2:0] LPSD_BL1 = 3'h0;
	localparam logic [2:0] LPSD_BL2 = 3'h1;
	localparam logic [2:0] LPSD_BL4 = 3'h2;
	localparam logic [2:0] LPSD_BL8 = 3'h3;
	localparam logic [2:0] LPSD_BLFULL = 3'h7;
	localparam logic [8:0] LPSD_FULL_LEN = 9'h1FF;
	localparam logic [2:0] LPSD_PARTIAL_REFRESH_FIELD_ALL = 3'h0;
	localparam logic [2:0] LPSD_PARTIAL_REFRESH_FIELD_HALF = 3'h1;
	localparam logic [2:0] LPSD_PARTIAL_REFRESH_FIELD_QTR = 3'h2;
	localparam logic [2:0] LPSD_PARTIAL_REFRESH_FIELD_EIGHTH = 3'h5;
	localparam logic [2:0] LPSD_PARTIAL_REFRESH_FIELD_SIXTEENTH = 3'h6;
	localparam logic [2:0] LPSD_DRV_LAST = 3'h4;
	// Command codes: {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] LPSD_CMD_NOP = 4'h7;
	localparam logic [3:0] LPSD_CMD_ACT = 4'h3;
	localparam logic [3:0] LPSD_CMD_RD = 4'h5;
	localparam logic [3:0] LPSD_CMD_WR = 4'h4;
	localparam logic [3:0] LPSD_CMD_BST = 4'h6;
	localparam logic [3:0] LPSD_CMD_PRE = 4'h2;
	localparam logic [3:0] LPSD_CMD_REF = 4'h1;
	localparam logic [3:0] LPSD_CMD_MRS = 4'h0;
	localparam logic [3:0] LPSD_CMD_DPD = 4'h6;
	// Temperature-compensated self refresh intervals in core cycles
	localparam int LPSD_SREF_COLD = 3120;
	localparam int LPSD_SREF_HOT = 780;
	typedef enum logic [3:0] {
		LPSD_ST_IDLE = 4'h1,
		LPSD_ST_SREF = 4'h2,
		LPSD_ST_DPD = 4'h4,
		LPSD_ST_RUN = 4'h8
	} lpsd_state_t;
endpackage : lpsd_pkg

// *** lpsd_core.sv ***
// Purpose: command decode, mode and extended configuration registers, read/write data path
// Assumes: all pins synchronous to core_clk_i; temperature sensor supplies a hot flag
// Notes: array storage is a small model with one word per bank and column
// Summary of operation
// (R1) Read latency is one, two or three cycles; first word valid at edge r+q.
// (R2) Data pins start driving one cycle before the first read word is valid; the core raises dq_oe_o in the same cycle as the first word.
// (R3) Controller keeps latency one to 50, two to 83, three to 166 MHz; the bench runs all three at 200 MHz.
// (R4) Write-burst bit low: bursts for both; high: writes touch one location only.
// (R5) Mode load with bank selects high-low writes extended register from address 9:0.
// (R6) Controller zeroes address bits 11:8 and 4:3 when loading extended register.
// (R7) Controller loads extended register only with banks idle and no burst running.
// (R8) Extended register keeps contents until written again.
// (R9) Controller waits the mode-load delay and loads only with all banks idle.
// (R10) Self refresh rate follows on-chip temperature, faster when hot, no controller help.
// (R11) Any bank is accessible normally; self refresh keeps only partial-refresh banks.
// (R12) Partial-refresh codes: 000 all, 001 half, 010 quarter, 101 eighth, 110 sixteenth.
// (R13) Drive codes: 000 full, 001 half, 010 quarter, 011 eighth, 100 three quarters.
// (R14) Commands decode from select and strobes with clock gate high per truth table.
// (R15) Chip select high ignores new commands; operations in progress continue.
// (R16) Refresh code: clock gate high auto refresh, low enters self refresh.
// (R17) Clock gate low with code low-high-high-low enters deep sleep.
// (R18) Masks block write bytes at once; on reads float lanes two clocks later.
// (R19) Mask bit n governs data byte lane n.
// (R20) Read/write column on address 8:0; line 10 requests auto precharge once.
// (R21) Precharge with line 10 high closes all banks, else the selected bank.
// (R22) Activate opens row on address 11:0 until that bank is precharged.
// (R23) Latency field bits 6:4: 001 one, 010 two, 011 three; others reserved.
// (R24) Burst-length field bits 2:0 sets length for reads and optionally writes.
module lpsd_core #(
	parameter int COLS = 16,
	parameter int SREF_COLD = lpsd_pkg::LPSD_SREF_COLD,
	parameter int SREF_HOT = lpsd_pkg::LPSD_SREF_HOT
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clock_gate_sample_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic bank_select_lo_i,
	input wire logic bank_select_hi_i,
	input wire logic [lpsd_pkg::LPSD_ADDR_W-1:0] addr_i,
	input wire logic [lpsd_pkg::LPSD_LANES-1:0] byte_mask_i,
	input wire logic [lpsd_pkg::LPSD_DATA_W-1:0] dq_i,
	input wire logic temp_hot_i,
	output logic [lpsd_pkg::LPSD_DATA_W-1:0] dq_o,
	output logic [lpsd_pkg::LPSD_LANES-1:0] dq_oe_o,
	output logic [2:0] partial_refresh_field_o,
	output logic [2:0] drive_strength_o,
	output logic self_refresh_o,
	output logic deep_sleep_mode_o,
	output logic sref_pulse_o,
	output logic [lpsd_pkg::LPSD_BANKS-1:0] bank_open_o
);
	localparam int CW = $clog2(COLS);
	typedef struct packed {
		lpsd_pkg::lpsd_state_t st;
		logic [13:0] mode;
		logic [13:0] ext;
		logic [3:0] bank_open;
		logic [3:0][11:0] open_row;
		logic rd_act;
		logic wr_act;
		logic [1:0] bank;
		logic [8:0] col;
		logic [8:0] left;
		logic autopre;
		logic [3:0] rd_pipe;
		logic [3:0][8:0] rd_col;
		logic [3:0][1:0] rd_bank;
		logic [1:0][3:0] mask_pipe;
		logic [31:0] dq;
		logic [3:0] dq_oe;
		logic [11:0] sref_cnt;
		logic sref_pulse;
		logic [3:0] sref_keep;
	} lpsd_state_s_t;
	lpsd_state_s_t r;
	lpsd_state_s_t next_r;
	logic [31:0] mem [0:4*COLS-1];

	function automatic logic [8:0] lpsd_burst_len(input logic [2:0] code);
		unique case (code)
			lpsd_pkg::LPSD_BL1: lpsd_burst_len = 9'h000;
			lpsd_pkg::LPSD_BL2: lpsd_burst_len = 9'h001;
			lpsd_pkg::LPSD_BL4: lpsd_burst_len = 9'h003;
			lpsd_pkg::LPSD_BL8: lpsd_burst_len = 9'h007;
			lpsd_pkg::LPSD_BLFULL: lpsd_burst_len = lpsd_pkg::LPSD_FULL_LEN;
			default: lpsd_burst_len = 9'h000;
		endcase
	endfunction : lpsd_burst_len

	// Banks kept alive through self refresh; finer sixteenths still keep bank 0
	function automatic logic [3:0] lpsd_partial_refresh_field_banks(input logic [2:0] code);
		unique case (code)
			lpsd_pkg::LPSD_PARTIAL_REFRESH_FIELD_ALL: lpsd_partial_refresh_field_banks = 4'hF; // R12
			lpsd_pkg::LPSD_PARTIAL_REFRESH_FIELD_HALF: lpsd_partial_refresh_field_banks = 4'h3; // R12
			lpsd_pkg::LPSD_PARTIAL_REFRESH_FIELD_QTR: lpsd_partial_refresh_field_banks = 4'h1; // R12
			lpsd_pkg::LPSD_PARTIAL_REFRESH_FIELD_EIGHTH: lpsd_partial_refresh_field_banks = 4'h1; // R12
			lpsd_pkg::LPSD_PARTIAL_REFRESH_FIELD_SIXTEENTH: lpsd_partial_refresh_field_banks = 4'h1; // R12
			default: lpsd_partial_refresh_field_banks = 4'hF;
		endcase
	endfunction : lpsd_partial_refresh_field_banks

	function automatic int unsigned lpsd_idx(input logic [1:0] b, input logic [8:0] c);
		lpsd_idx = 32'({b, c[CW-1:0]});
	endfunction : lpsd_idx

	logic [3:0] cmd;
	logic [1:0] bsel;
	logic [2:0] lat;
	logic [31:0] wr_merge;
	logic do_write;
	logic [8:0] wr_col;
	logic [1:0] wr_bank;
	logic rd_v;
	logic [1:0] rd_b;
	logic [8:0] rd_c;
	assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
	assign bsel = {bank_select_hi_i, bank_select_lo_i};
	assign lat = r.mode[lpsd_pkg::LPSD_CL_LSB +: 3];

	always_comb
	begin
		next_r = r;
		next_r.sref_pulse = 1'b0;
		do_write = 1'b0;
		wr_col = r.col;
		wr_bank = r.bank;
		// Burst sequencing continues until a new read, write or burst stop below overrides it
		if (r.rd_act || r.wr_act)
		begin
			if (r.left == 9'h000)
			begin
				next_r.rd_act = 1'b0;
				next_r.wr_act = 1'b0;
				if (r.autopre && r.mode[2:0] != lpsd_pkg::LPSD_BLFULL)
					next_r.bank_open[r.bank] = 1'b0; // R20
			end
			else
				next_r.left = r.left - 9'h001;
			next_r.col = r.col + 9'h001;
			if (r.wr_act && r.left != 9'h000)
			begin
				do_write = 1'b1;
				wr_col = r.col + 9'h001;
			end
		end
		// Read latency pipe: slot k fires k+1 cycles after the command
		next_r.rd_pipe = {r.rd_pipe[2:0], r.rd_act};
		next_r.rd_col = {r.rd_col[2:0], r.col};
		next_r.rd_bank = {r.rd_bank[2:0], r.bank};
		next_r.mask_pipe = {r.mask_pipe[0], byte_mask_i};
		next_r.dq_oe = 4'h0;
		next_r.dq = 32'h0000_0000;
		unique case (r.st)
			lpsd_pkg::LPSD_ST_IDLE, lpsd_pkg::LPSD_ST_RUN:
			begin
				if (!clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_DPD)
				begin
					next_r.st = lpsd_pkg::LPSD_ST_DPD; // R17
					next_r.bank_open = 4'h0;
				end
				else if (!clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_REF)
				begin
					next_r.st = lpsd_pkg::LPSD_ST_SREF; // R16
					next_r.sref_keep = lpsd_partial_refresh_field_banks(r.ext[2:0]); // R11
					next_r.sref_cnt = 12'h000;
				end
				else if (clock_gate_sample_i && !cs_n_i) // R14 R15
				begin
					unique case (cmd)
						lpsd_pkg::LPSD_CMD_ACT:
						begin
							next_r.bank_open[bsel] = 1'b1; // R22
							next_r.open_row[bsel] = addr_i; // R22
						end
						lpsd_pkg::LPSD_CMD_RD, lpsd_pkg::LPSD_CMD_WR:
						begin
							next_r.bank = bsel; // R20
							next_r.col = addr_i[8:0]; // R20
							next_r.autopre = addr_i[lpsd_pkg::LPSD_AP_BIT]; // R20
							next_r.rd_act = (cmd == lpsd_pkg::LPSD_CMD_RD);
							next_r.wr_act = (cmd == lpsd_pkg::LPSD_CMD_WR);
							next_r.left = lpsd_burst_len(r.mode[2:0]); // R24
							if (cmd == lpsd_pkg::LPSD_CMD_WR)
							begin
								if (r.mode[lpsd_pkg::LPSD_WB_BIT])
									next_r.left = 9'h000; // R4
								do_write = 1'b1;
								wr_col = addr_i[8:0];
								wr_bank = bsel;
							end
						end
						lpsd_pkg::LPSD_CMD_BST:
						begin
							next_r.rd_act = 1'b0;
							next_r.wr_act = 1'b0;
						end
						lpsd_pkg::LPSD_CMD_PRE:
						begin
							if (addr_i[lpsd_pkg::LPSD_AP_BIT])
								next_r.bank_open = 4'h0; // R21
							else
								next_r.bank_open[bsel] = 1'b0; // R21
						end
						lpsd_pkg::LPSD_CMD_MRS:
						begin
							if (bsel == 2'h2)
								next_r.ext = {bsel, 2'h0, addr_i[9:0]}; // R5 R8
							else if (bsel == 2'h0)
								next_r.mode = {bsel, addr_i}; // R5
						end
						default:
						begin
						end
					endcase
				end
				next_r.st = (next_r.st == lpsd_pkg::LPSD_ST_DPD || next_r.st == lpsd_pkg::LPSD_ST_SREF)
					? next_r.st : ((next_r.bank_open != 4'h0) ? lpsd_pkg::LPSD_ST_RUN
					: lpsd_pkg::LPSD_ST_IDLE);
			end
			lpsd_pkg::LPSD_ST_SREF:
			begin
				// Hot die shortens the interval between internal refreshes
				if (r.sref_cnt >= (temp_hot_i ? 12'(SREF_HOT - 1) : 12'(SREF_COLD - 1))) // R10
				begin
					next_r.sref_cnt = 12'h000;
					next_r.sref_pulse = 1'b1;
				end
				else
					next_r.sref_cnt = r.sref_cnt + 12'h001;
				if (clock_gate_sample_i)
					next_r.st = lpsd_pkg::LPSD_ST_IDLE;
			end
			lpsd_pkg::LPSD_ST_DPD:
			begin
				// Exit only through reset: full initialisation is needed anyway
			end
			default: next_r.st = lpsd_pkg::LPSD_ST_IDLE;
		endcase
		// Output flops load one edge before the word is due, so pins are valid at r+q
		// Latency one has no spare edge: it takes the beat from this edge's own decode
		unique case (lat) // R23
			lpsd_pkg::LPSD_CL1:
			begin
				rd_v = next_r.rd_act;
				rd_b = next_r.bank;
				rd_c = next_r.col;
			end
			lpsd_pkg::LPSD_CL2:
			begin
				rd_v = r.rd_act;
				rd_b = r.bank;
				rd_c = r.col;
			end
			lpsd_pkg::LPSD_CL3:
			begin
				rd_v = r.rd_pipe[0];
				rd_b = r.rd_bank[0];
				rd_c = r.rd_col[0];
			end
			default:
			begin
				// Reserved latency codes return no data
				rd_v = 1'b0;
				rd_b = r.bank;
				rd_c = r.col;
			end
		endcase
		if (rd_v) // R1 R2
		begin
			next_r.dq = mem[lpsd_idx(rd_b, rd_c)];
			// Mask registered two edges before the valid edge, one before this load
			next_r.dq_oe = ~r.mask_pipe[lpsd_pkg::LPSD_MASK_RD_DLY - 2]; // R18 R19
		end
		wr_merge = mem[lpsd_idx(wr_bank, wr_col)];
		for (int i = 0; i < lpsd_pkg::LPSD_LANES; i++)
		begin
			if (!byte_mask_i[i]) // R18 R19
				wr_merge[8*i +: 8] = dq_i[8*i +: 8];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			r <= '0;
			r.st <= lpsd_pkg::LPSD_ST_IDLE;
			r.mode <= lpsd_pkg::LPSD_MODE_RST;
			r.ext <= lpsd_pkg::LPSD_EXT_RST;
		end
		else
			r <= next_r;
	end

	// Unrefreshed banks lose data on self refresh exit
	always_ff @(posedge core_clk_i)
	begin
		if (do_write)
			mem[lpsd_idx(wr_bank, wr_col)] <= wr_merge;
		else if (r.st == lpsd_pkg::LPSD_ST_SREF && clock_gate_sample_i)
		begin
			for (int j = 0; j < 4 * COLS; j++)
			begin
				if (!r.sref_keep[j / COLS]) // R11
					mem[j] <= 32'h0000_0000;
			end
		end
	end

	assign dq_o = r.dq;
	assign dq_oe_o = r.dq_oe;
	assign partial_refresh_field_o = r.ext[lpsd_pkg::LPSD_PARTIAL_REFRESH_FIELD_LSB +: 3];
	assign drive_strength_o = r.ext[lpsd_pkg::LPSD_DRV_LSB +: 3]; // R13
	// One-hot state bits drive the level outputs straight from the flops
	assign self_refresh_o = r.st[1];
	assign deep_sleep_mode_o = r.st[2];
	assign sref_pulse_o = r.sref_pulse;
	assign bank_open_o = r.bank_open;

	a_ext_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
		(clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_MRS && bsel == 2'h2
			&& r.st != lpsd_pkg::LPSD_ST_SREF && r.st != lpsd_pkg::LPSD_ST_DPD)
		|=> r.ext[9:0] == $past(addr_i[9:0]))
		else $error("extended register not loaded");
	a_ext_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R8
		!(clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_MRS && bsel == 2'h2)
		|=> $stable(r.ext))
		else $error("extended register changed without load");
	a_cs_ignore: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		(cs_n_i && r.st == lpsd_pkg::LPSD_ST_IDLE) |=> $stable(r.mode) && $stable(r.bank_open))
		else $error("command taken while deselected");
	a_dpd_enter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R17
		(!clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_DPD && r.st == lpsd_pkg::LPSD_ST_IDLE)
		|=> deep_sleep_mode_o)
		else $error("deep sleep not entered");
	a_sref_enter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R16
		(!clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_REF && r.st == lpsd_pkg::LPSD_ST_IDLE)
		|=> self_refresh_o)
		else $error("self refresh not entered");
	a_pre_all: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R21
		(clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_PRE && addr_i[10]
			&& r.st == lpsd_pkg::LPSD_ST_RUN) |=> bank_open_o == 4'h0)
		else $error("precharge all left a bank open");
	a_act_open: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R22
		(clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_ACT && r.st == lpsd_pkg::LPSD_ST_IDLE)
		|=> bank_open_o[$past(bsel)])
		else $error("activate did not open bank");
	sequence s_read_cmd;
		clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_RD && lat == lpsd_pkg::LPSD_CL2
			&& byte_mask_i == 4'h0 && r.st == lpsd_pkg::LPSD_ST_RUN && !r.rd_act && !r.wr_act;
	endsequence
	a_read_lat2: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R1 R2
		s_read_cmd ##1 $stable(lat) |=> dq_oe_o == 4'hF)
		else $error("read data not driven at latency two");
	a_wr_single: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
		(clock_gate_sample_i && cmd == lpsd_pkg::LPSD_CMD_WR && r.mode[9]
			&& r.st == lpsd_pkg::LPSD_ST_RUN) |=> r.left == 9'h000)
		else $error("write burst not single in single mode");
endmodule : lpsd_core

// *** lpsd_ctl_model.sv ***
// Purpose: command-pin model of the memory controller facing lpsd_core
// Assumes: pins change at the falling edge and hold for a full cycle
// Notes: each command is followed by one NOP cycle carrying the next beat
module lpsd_ctl_model (
	input wire logic core_clk_i,
	output logic cke_o,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic bank_select_lo_o,
	output logic bank_select_hi_o,
	output logic [11:0] addr_o,
	output logic [3:0] mask_o,
	output logic [31:0] dq_o
);
	initial
	begin
		{cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 5'h17;
		{bank_select_hi_o, bank_select_lo_o, addr_o, mask_o, dq_o} = '0;
	end
	task cmd(input logic [4:0] k, input logic [1:0] ba, input logic [11:0] a,
		input logic [3:0] m, input logic [31:0] d, input logic [31:0] d2);
		@(negedge core_clk_i);
		{cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = k;
		{bank_select_hi_o, bank_select_lo_o} = ba;
		addr_o = a;
		mask_o = m;
		dq_o = d;
		@(negedge core_clk_i);
		// Gap covers mode_load_wait; address shows no stale value
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = lpsd_pkg::LPSD_CMD_NOP;
		addr_o = ~a;
		mask_o = 4'h0;
		dq_o = d2;
	endtask : cmd
	// Only called with every bank idle and no burst running
	task ext(input logic [2:0] p, input logic [2:0] s);
		cmd({1'b1, lpsd_pkg::LPSD_CMD_MRS}, 2'h2, {4'h0, s, 2'h0, p}, 4'h0, '0, '0);
	endtask : ext
endmodule : lpsd_ctl_model

// *** tb_lpsd_core.sv ***
// Purpose: self-checking bench for lpsd_core
// Assumes: self-refresh intervals shortened to 8 and 2 cycles
// Notes: random data from a fixed seed, corner cases by hand
module tb_lpsd_core;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] ACT = {1'b1, lpsd_pkg::LPSD_CMD_ACT};
	localparam logic [4:0] MRS = {1'b1, lpsd_pkg::LPSD_CMD_MRS};
	localparam logic [4:0] PRE = {1'b1, lpsd_pkg::LPSD_CMD_PRE};
	localparam logic [2:0] PL [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
	logic core_clk, rst_n, cke, cs_n, ras_n, cas_n, we_n, bs_lo, bs_hi, hot, sr, dsm, sp;
	logic [11:0] addr;
	logic [3:0] bm, oe, bo, col, m;
	logic [31:0] dqi, dqo, d, d2, d3;
	logic [2:0] prf, drv;
	logic [1:0] b;
	int n_mismatch, check_count, cyc, hot_n, cold_n;
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	lpsd_ctl_model ctl (.core_clk_i(core_clk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
		.cas_n_o(cas_n), .we_n_o(we_n), .bank_select_lo_o(bs_lo), .bank_select_hi_o(bs_hi),
		.addr_o(addr), .mask_o(bm), .dq_o(dqi));
	lpsd_core #(.COLS(16), .SREF_COLD(8), .SREF_HOT(2)) uut (.core_clk_i(core_clk),
		.rst_n_i(rst_n), .clock_gate_sample_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n),
		.cas_n_i(cas_n), .we_n_i(we_n), .bank_select_lo_i(bs_lo), .bank_select_hi_i(bs_hi),
		.addr_i(addr), .byte_mask_i(bm), .dq_i(dqi), .temp_hot_i(hot), .dq_o(dqo),
		.dq_oe_o(oe), .partial_refresh_field_o(prf), .drive_strength_o(drv),
		.self_refresh_o(sr), .deep_sleep_mode_o(dsm), .sref_pulse_o(sp), .bank_open_o(bo));
	function automatic logic [31:0] lanes(input logic [3:0] mk);
		for (int i = 0; i < 4; i++)
			lanes[8*i +: 8] = {8{~mk[i]}};
	endfunction : lanes
	function automatic logic [11:0] mreg(input logic [2:0] q, input logic [2:0] bl, input logic wb);
		return {2'h0, wb, 2'h0, q, 1'b0, bl};
	endfunction : mreg
	function automatic logic [11:0] cadr(input logic a10, input logic [3:0] c);
		return {1'b0, a10, 6'h0, c};
	endfunction : cadr
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask : chk
	task wr(input logic [1:0] ba, input logic [3:0] c, input logic [3:0] mk, input logic [31:0] x,
		input logic [31:0] y);
		ctl.cmd({1'b1, lpsd_pkg::LPSD_CMD_WR}, ba, cadr(1'b0, c), mk, x, y);
	endtask : wr
	task rd(input logic [1:0] ba, input logic [3:0] c, input logic a10, input logic [3:0] mk,
		input int q, input logic [31:0] x);
		ctl.cmd({1'b1, lpsd_pkg::LPSD_CMD_RD}, ba, cadr(a10, c), mk, ~x, x);
		// Word must already stand on the pins at edge r+q: look just after edge r+q-1
		repeat (q - 1) @(posedge core_clk);
		#1;
		chk("dq_oe_o", {28'h0, ~mk}, {28'h0, oe});
		chk("dq_o", x & lanes(mk), dqo & lanes(mk));
	endtask : rd
	task wrap_up;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial
	begin
		void'($urandom(32'h5059ab23));
		rst_n = 1'b0;
		hot = 1'b0;
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		chk("reset outputs", 32'h0, {oe, prf, drv, bo, sr, dsm});
		for (int i = 0; i < 5; i++)
		begin
			ctl.ext(PL[i], 3'(i));
			@(posedge core_clk);
			#1;
			chk("partial_refresh_field_o", {29'h0, PL[i]}, {29'h0, prf});
			chk("drive_strength_o", i, {29'h0, drv});
		end
		// Base load and a deselected load must both leave the extended fields alone
		ctl.cmd(MRS, 2'h0, mreg(lpsd_pkg::LPSD_CL2, lpsd_pkg::LPSD_BL1, 1'b0), 4'h0, '0, '0);
		ctl.cmd(5'h18, 2'h2, 12'h0E7, 4'h0, '0, '0);
		@(posedge core_clk);
		#1;
		chk("config kept", 32'h26, {26'h0, drv, prf});
		// Latency choice is functional only: the model has no access time to violate
		for (int q = 1; q <= 3; q++)
		begin
			ctl.cmd(MRS, 2'h0, mreg(3'(q), lpsd_pkg::LPSD_BL1, 1'b0), 4'h0, '0, '0);
			b = 2'($urandom);
			col = 4'($urandom);
			m = 4'($urandom);
			d = $urandom;
			d2 = $urandom;
			ctl.cmd(ACT, b, 12'($urandom), 4'h0, '0, '0);
			#1;
			chk("bank_open_o", 32'h1 << b, {28'h0, bo});
			wr(b, col, 4'h0, d, ~d);
			wr(b, col, m, d2, ~d2);
			rd(b, col, 1'b0, (q == 2) ? m : 4'h0, q, (d & ~lanes(m)) | (d2 & lanes(m)));
			ctl.cmd(PRE, b, 12'h0, 4'h0, '0, '0);
			#1;
			chk("bank_open_o", 32'h0, {28'h0, bo});
		end
		ctl.cmd(MRS, 2'h0, mreg(lpsd_pkg::LPSD_CL2, lpsd_pkg::LPSD_BL2, 1'b0), 4'h0, '0, '0);
		col = 4'($urandom) & 4'hE;
		d = $urandom;
		d2 = $urandom;
		d3 = $urandom;
		ctl.cmd(ACT, 2'h1, 12'h0, 4'h0, '0, '0);
		ctl.cmd(ACT, 2'h2, 12'hFFF, 4'h0, '0, '0);
		wr(2'h1, col, 4'h0, d, d2);
		rd(2'h1, col, 1'b0, 4'h0, 2, d);
		@(posedge core_clk);
		#1;
		chk("second beat", d2, dqo);
		ctl.cmd(PRE, 2'h3, 12'h400, 4'h0, '0, '0);
		#1;
		chk("all banks closed", 32'h0, {28'h0, bo});
		// Single-location writes leave the second column holding the old beat
		ctl.cmd(MRS, 2'h0, mreg(lpsd_pkg::LPSD_CL2, lpsd_pkg::LPSD_BL2, 1'b1), 4'h0, '0, '0);
		ctl.cmd(ACT, 2'h1, 12'h0, 4'h0, '0, '0);
		wr(2'h1, col, 4'h0, d3, ~d2);
		rd(2'h1, col, 1'b1, 4'h0, 2, d3);
		@(posedge core_clk);
		#1;
		chk("single write", d2, dqo);
		repeat (3) @(posedge core_clk);
		#1;
		chk("auto precharge", 32'h0, {28'h0, bo});
		ctl.cmd({1'b1, lpsd_pkg::LPSD_CMD_REF}, 2'h0, 12'h0, 4'h0, '0, '0);
		@(posedge core_clk);
		#1;
		chk("auto refresh", 32'h0, {31'h0, sr});
		ctl.cmd({1'b0, lpsd_pkg::LPSD_CMD_REF}, 2'h0, 12'h0, 4'h0, '0, '0);
		@(posedge core_clk);
		#1;
		chk("self_refresh_o", 32'h1, {31'h0, sr});
		repeat (64)
		begin
			@(posedge core_clk);
			#1;
			cold_n += int'(sp);
		end
		@(negedge core_clk);
		hot = 1'b1;
		repeat (64)
		begin
			@(posedge core_clk);
			#1;
			hot_n += int'(sp);
		end
		chk("refresh rate", 32'h1, {31'h0, cold_n > 0 && hot_n > 2 * cold_n});
		// Exit with the sixteenth coverage loaded: bank 1 must come back empty
		ctl.cmd(5'h17, 2'h0, 12'h0, 4'h0, '0, '0);
		#1;
		chk("self refresh exit", 32'h0, {31'h0, sr});
		ctl.cmd(ACT, 2'h1, 12'h0, 4'h0, '0, '0);
		rd(2'h1, col, 1'b0, 4'h0, 2, 32'h0);
		@(negedge core_clk);
		rst_n = 1'b0;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		ctl.cmd({1'b0, lpsd_pkg::LPSD_CMD_DPD}, 2'h0, 12'h0, 4'h0, '0, '0);
		@(posedge core_clk);
		#1;
		chk("deep_sleep_mode_o", 32'h1, {31'h0, dsm});
		ctl.cmd(ACT, 2'h0, 12'h0, 4'h0, '0, '0);
		#1;
		chk("ignored while asleep", 32'h0, {28'h0, bo});
		wrap_up();
	end
endmodule : tb_lpsd_core
